// >>> rtl/alu_pkg.sv
// Functional notes
// RQ1: divide {high word, low src_a} by 32-bit divisor
// RQ2: high word holds unspecified value after divide
// RQ3: signed quotient truncates toward zero
// RQ4: overflow saturates to largest signed word; negative overflow saturates to SAT_NEG instead
// RQ5: normal quotient sign-extended into destination
// RQ6: only cc form updates flags, after saturation
// RQ7: cc form sets overflow, clears carries
// RQ8: divide register form with bits 12:5 illegal
// RQ9: high immediate placed at 31:10, rest zeroed
// RQ10: high immediate never touches condition codes
// RQ11: high immediate, dest 0, field 0 is nop
// RQ12: shift count from src_b or immediate, 5/6 bits
// RQ13: left shifts move all 64 bits, zero fill
// RQ14: word logical right zero-fills, upper word zero
// RQ15: wide logical right zero-fills from top
// RQ16: word arithmetic right fills with bit 31
// RQ17: wide arithmetic right replicates bit 63
// RQ18: zero count moves nothing, word forms still extend
// RQ19: shifts never modify condition codes
// RQ20: word shifts with bits 11:5 set illegal
// RQ21: wide shifts with reserved bits set illegal
package alu_pkg;
	// =====================================================================
	// register map (byte addresses)
	localparam int unsigned ADDR_W = 6;
	localparam logic [5:0] OFS_CMD = 6'h00;
	localparam logic [5:0] OFS_INSTR = 6'h04;
	localparam logic [5:0] OFS_SRC_A_LO = 6'h08;
	localparam logic [5:0] OFS_SRC_A_HI = 6'h0C;
	localparam logic [5:0] OFS_SRC_B_LO = 6'h10;
	localparam logic [5:0] OFS_SRC_B_HI = 6'h14;
	localparam logic [5:0] OFS_HIGH_WORD = 6'h18;
	localparam logic [5:0] OFS_RESULT_LO = 6'h1C;
	localparam logic [5:0] OFS_RESULT_HI = 6'h20;
	localparam logic [5:0] OFS_STATUS = 6'h24;
	localparam logic [5:0] OFS_CC = 6'h28;
	// =====================================================================
	// operation codes written to the command register
	localparam logic [2:0] OP_DIV = 3'h0;
	localparam logic [2:0] OP_DIVCC = 3'h1;
	localparam logic [2:0] OP_HI_IMM = 3'h2;
	localparam logic [2:0] OP_SLL = 3'h3;
	localparam logic [2:0] OP_SRL = 3'h4;
	localparam logic [2:0] OP_SRA = 3'h5;
	// =====================================================================
	// instruction word fields
	localparam int unsigned BIT_IMM_SEL = 13;
	localparam int unsigned BIT_WIDE_SEL = 12;
	localparam int unsigned RD_LSB = 25;
	localparam int unsigned RD_W = 5;
	localparam int unsigned HI_IMM_W = 22;
	localparam int unsigned HI_IMM_POS = 10;
	localparam int unsigned SIMM_W = 13;
	localparam logic [5:0] CNT_MASK_WORD = 6'h1F;
	localparam logic [5:0] CNT_MASK_WIDE = 6'h3F;
	// =====================================================================
	// status and condition-code bits
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_DONE = 1;
	localparam int unsigned ST_ILLEGAL = 2;
	localparam int unsigned ST_NOP = 3;
	localparam int unsigned ST_OVF = 4;
	localparam int unsigned ST_DIVZERO = 5;
	localparam int unsigned CC_W = 8;
	localparam int unsigned CC_IC = 0;
	localparam int unsigned CC_IV = 1;
	localparam int unsigned CC_IZ = 2;
	localparam int unsigned CC_IN = 3;
	localparam int unsigned CC_XC = 4;
	localparam int unsigned CC_XV = 5;
	localparam int unsigned CC_XZ = 6;
	localparam int unsigned CC_XN = 7;
	// =====================================================================
	// divide constants
	localparam int unsigned DIV_STEPS = 64;
	localparam logic [63:0] SAT_POS = 64'h0000_0000_7FFF_FFFF;
	localparam logic [63:0] SAT_NEG = 64'hFFFF_FFFF_8000_0000;
	localparam logic [63:0] OVF_LIMIT = 64'h0000_0000_8000_0000;
endpackage

// >>> rtl/div_unit.sv
`timescale 1ns/1ps
module div_unit import alu_pkg::*; #(
	parameter int unsigned STEPS = DIV_STEPS
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// request
	input wire logic start,
	input wire logic [63:0] dividend,
	input wire logic [31:0] divisor,
	// answer
	output logic done,
	output logic [31:0] quotient,
	output logic overflow,
	output logic div_zero
);
	// =====================================================================
	// state
	typedef struct packed {
		logic busy;
		logic [6:0] cnt;
		logic [32:0] rem;
		logic [63:0] dvd;
		logic [31:0] dsr;
		logic neg;
		logic done;
		logic [31:0] quot;
		logic ovf;
		logic dz;
	} div_state_t;

	div_state_t cur_ff;
	div_state_t nxt_state;

	assign done = cur_ff.done;
	assign quotient = cur_ff.quot;
	assign overflow = cur_ff.ovf;
	assign div_zero = cur_ff.dz;

	// =====================================================================
	// restoring divide on magnitudes; truncation toward zero falls out
	// of dividing magnitudes and restoring the sign afterwards
	always_comb begin
		logic [32:0] rem_sh;
		logic qbit;
		logic [63:0] q;
		rem_sh = '0;
		qbit = 1'b0;
		q = '0;
		nxt_state = cur_ff;
		nxt_state.done = 1'b0;
		if (start && !cur_ff.busy) begin
			nxt_state.dz = (divisor == 32'h0000_0000);
			nxt_state.done = (divisor == 32'h0000_0000);
			nxt_state.busy = (divisor != 32'h0000_0000);
			nxt_state.dvd = dividend[63] ? 64'(-dividend) : dividend;
			nxt_state.dsr = divisor[31] ? 32'(-divisor) : divisor;
			nxt_state.neg = dividend[63] ^ divisor[31]; // see RQ3
			nxt_state.rem = '0;
			nxt_state.cnt = '0;
			nxt_state.ovf = 1'b0;
		end else if (cur_ff.busy) begin
			rem_sh = {cur_ff.rem[31:0], cur_ff.dvd[63]};
			qbit = (rem_sh >= {1'b0, cur_ff.dsr});
			nxt_state.rem = qbit ? 33'(rem_sh - {1'b0, cur_ff.dsr}) : rem_sh;
			q = {cur_ff.dvd[62:0], qbit};
			nxt_state.dvd = q;
			nxt_state.cnt = 7'(cur_ff.cnt + 7'h01);
			if (cur_ff.cnt == 7'(STEPS - 1)) begin
				nxt_state.busy = 1'b0;
				nxt_state.done = 1'b1;
				nxt_state.ovf = cur_ff.neg ? (q > OVF_LIMIT) : (q >= OVF_LIMIT); // see RQ4
				nxt_state.quot = cur_ff.neg ? 32'(-q[31:0]) : q[31:0]; // see RQ3
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_state;
		end
	end

	// =====================================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	div_bounded_a: assert property (start && !cur_ff.busy |-> ##[1:70] done) // see RQ1
		else $error("divide did not finish in time");
	div_trunc_a: assert property (done && !overflow && !div_zero && cur_ff.neg
		|-> quotient[31] || quotient == 32'h0000_0000) // see RQ3
		else $error("negative quotient lost its sign");
	div_ovf_c: cover property (done && overflow);
endmodule

// >>> rtl/int_div_shift.sv
`timescale 1ns/1ps
module int_div_shift import alu_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// avalon-mm slave
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// register file write-back
	output logic wb_valid,
	output logic [RD_W-1:0] wb_dest,
	output logic [63:0] wb_data,
	// condition codes and exception
	output logic [CC_W-1:0] cond_codes,
	output logic illegal_op
);
	// =====================================================================
	// state
	typedef enum logic [0:0] {ST_IDLE, ST_DIV} phase_t;

	typedef struct packed {
		phase_t st;
		logic wait_req;
		logic [31:0] rdata;
		logic [31:0] instr;
		logic [63:0] src_a;
		logic [63:0] src_b;
		logic [31:0] high_word;
		logic [63:0] result;
		logic [CC_W-1:0] cc;
		logic [2:0] op;
		logic done;
		logic illegal;
		logic nop;
		logic ovf;
		logic divzero;
		logic div_start;
		logic div_neg;
		logic wb_valid;
		logic illegal_pulse;
	} core_t;

	core_t cur_ff;
	core_t nxt_core;

	logic div_done;
	logic [31:0] div_quot;
	logic div_ovf;
	logic div_dz;
	logic [31:0] divisor;

	// =====================================================================
	// helpers
	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [63:0] do_shift(input logic [2:0] op, input logic wide,
		input logic [63:0] a, input logic [5:0] cnt);
		logic [31:0] w;
		logic [63:0] r;
		w = '0;
		r = '0;
		case (op)
			OP_SLL: begin
				r = a << cnt; // see RQ13
			end
			OP_SRL: begin
				if (wide) begin
					r = a >> cnt; // see RQ15
				end else begin
					w = a[31:0] >> cnt[4:0];
					r = {32'h0000_0000, w}; // see RQ14
				end
			end
			OP_SRA: begin
				if (wide) begin
					r = $signed(a) >>> cnt; // see RQ17
				end else begin
					w = $signed(a[31:0]) >>> cnt[4:0];
					r = {{32{a[31]}}, w}; // see RQ16
				end
			end
			default: begin
				r = a;
			end
		endcase
		return r;
	endfunction

	// reserved-bit screen used only by the command decode; the checks test the bits directly
	function automatic logic is_illegal(input logic [2:0] op, input logic [31:0] ins);
		logic imm;
		logic wide;
		logic bad;
		imm = ins[BIT_IMM_SEL];
		wide = ins[BIT_WIDE_SEL];
		bad = 1'b0;
		case (op)
			OP_DIV, OP_DIVCC: begin
				bad = !imm && (ins[12:5] != 8'h00); // see RQ8
			end
			OP_HI_IMM: begin
				bad = 1'b0;
			end
			OP_SLL, OP_SRL, OP_SRA: begin
				if (wide) begin
					bad = (ins[11:6] != 6'h00) || (!imm && ins[5]); // see RQ21
				end else begin
					bad = (ins[11:5] != 7'h00); // see RQ20
				end
			end
			default: begin
				bad = 1'b1;
			end
		endcase
		return bad;
	endfunction

	// =====================================================================
	// divider
	// immediate divisor is the sign-extended short immediate's low word
	assign divisor = cur_ff.instr[BIT_IMM_SEL]
		? {{(32-SIMM_W){cur_ff.instr[SIMM_W-1]}}, cur_ff.instr[SIMM_W-1:0]}
		: cur_ff.src_b[31:0]; // see RQ1

	div_unit #(
		.STEPS(DIV_STEPS)
	) u_div (
		.clk(clk),
		.reset_n(reset_n),
		.start(cur_ff.div_start),
		.dividend({cur_ff.high_word, cur_ff.src_a[31:0]}), // see RQ1
		.divisor(divisor),
		.done(div_done),
		.quotient(div_quot),
		.overflow(div_ovf),
		.div_zero(div_dz)
	);

	// =====================================================================
	// next state
	always_comb begin
		logic [2:0] op;
		logic [5:0] cnt;
		logic [63:0] res;
		op = writedata[2:0];
		cnt = '0;
		res = '0;
		nxt_core = cur_ff;
		nxt_core.wait_req = 1'b1;
		nxt_core.div_start = 1'b0;
		nxt_core.wb_valid = 1'b0;
		nxt_core.illegal_pulse = 1'b0;
		// bus: waitrequest drops one cycle after the request, read data
		// is loaded at the same edge so it stands when the master samples
		if ((read || write) && cur_ff.wait_req) begin
			nxt_core.wait_req = 1'b0;
			if (read) begin
				case (address)
					OFS_INSTR: nxt_core.rdata = cur_ff.instr;
					OFS_SRC_A_LO: nxt_core.rdata = cur_ff.src_a[31:0];
					OFS_SRC_A_HI: nxt_core.rdata = cur_ff.src_a[63:32];
					OFS_SRC_B_LO: nxt_core.rdata = cur_ff.src_b[31:0];
					OFS_SRC_B_HI: nxt_core.rdata = cur_ff.src_b[63:32];
					OFS_HIGH_WORD: nxt_core.rdata = cur_ff.high_word;
					OFS_RESULT_LO: nxt_core.rdata = cur_ff.result[31:0];
					OFS_RESULT_HI: nxt_core.rdata = cur_ff.result[63:32];
					OFS_STATUS: nxt_core.rdata = {26'h0, cur_ff.divzero, cur_ff.ovf,
						cur_ff.nop, cur_ff.illegal, cur_ff.done, (cur_ff.st == ST_DIV)};
					OFS_CC: nxt_core.rdata = {24'h0, cur_ff.cc};
					default: nxt_core.rdata = '0;
				endcase
			end
		end
		if (write && !cur_ff.wait_req) begin
			case (address)
				OFS_INSTR: nxt_core.instr = be_merge(cur_ff.instr, writedata, byteenable);
				OFS_SRC_A_LO: nxt_core.src_a[31:0] = be_merge(cur_ff.src_a[31:0], writedata, byteenable);
				OFS_SRC_A_HI: nxt_core.src_a[63:32] = be_merge(cur_ff.src_a[63:32], writedata, byteenable);
				OFS_SRC_B_LO: nxt_core.src_b[31:0] = be_merge(cur_ff.src_b[31:0], writedata, byteenable);
				OFS_SRC_B_HI: nxt_core.src_b[63:32] = be_merge(cur_ff.src_b[63:32], writedata, byteenable);
				OFS_HIGH_WORD: nxt_core.high_word = be_merge(cur_ff.high_word, writedata, byteenable);
				OFS_CC: begin
					// the divider owns the flags while it runs
					if (cur_ff.st == ST_IDLE && byteenable[0]) begin
						nxt_core.cc = writedata[CC_W-1:0];
					end
				end
				OFS_CMD: begin
					// a command while busy is dropped; operands are already latched
					if (cur_ff.st == ST_IDLE && byteenable[0]) begin
						nxt_core.op = op;
						nxt_core.done = 1'b0;
						nxt_core.nop = 1'b0;
						nxt_core.ovf = 1'b0;
						nxt_core.divzero = 1'b0;
						nxt_core.illegal = is_illegal(op, cur_ff.instr);
						nxt_core.illegal_pulse = is_illegal(op, cur_ff.instr);
						if (is_illegal(op, cur_ff.instr)) begin
							nxt_core.done = 1'b1;
						end else if (op == OP_DIV || op == OP_DIVCC) begin
							nxt_core.div_start = 1'b1;
							nxt_core.st = ST_DIV;
							// the truncated low word cannot tell which way an overflow went
							nxt_core.div_neg = cur_ff.high_word[31] ^ divisor[31]; // see RQ4
						end else if (op == OP_HI_IMM) begin
							nxt_core.done = 1'b1;
							if (cur_ff.instr[RD_LSB +: RD_W] == '0 &&
								cur_ff.instr[HI_IMM_W-1:0] == '0) begin
								nxt_core.nop = 1'b1; // see RQ11
							end else begin
								// flags are left alone here
								nxt_core.result = {32'h0000_0000, cur_ff.instr[HI_IMM_W-1:0],
									{HI_IMM_POS{1'b0}}}; // see RQ9 see RQ10
								nxt_core.wb_valid = 1'b1;
							end
						end else begin
							cnt = (cur_ff.instr[BIT_IMM_SEL] ? cur_ff.instr[5:0] : cur_ff.src_b[5:0])
								& (cur_ff.instr[BIT_WIDE_SEL] ? CNT_MASK_WIDE : CNT_MASK_WORD); // see RQ12
							// a zero count still runs through the word extension
							nxt_core.result = do_shift(op, cur_ff.instr[BIT_WIDE_SEL],
								cur_ff.src_a, cnt); // see RQ18 see RQ19
							nxt_core.wb_valid = 1'b1;
							nxt_core.done = 1'b1;
						end
					end
				end
				default: begin
				end
			endcase
		end
		// high word is simply left as it was after a divide
		if (cur_ff.st == ST_DIV && div_done) begin // see RQ2
			nxt_core.st = ST_IDLE;
			nxt_core.done = 1'b1;
			nxt_core.divzero = div_dz;
			nxt_core.ovf = div_ovf && !div_dz;
			if (!div_dz) begin
				res = div_ovf ? (cur_ff.div_neg ? SAT_NEG : SAT_POS)
					: {{32{div_quot[31]}}, div_quot}; // see RQ4 see RQ5
				nxt_core.result = res;
				nxt_core.wb_valid = 1'b1;
				if (cur_ff.op == OP_DIVCC) begin
					nxt_core.cc[CC_IN] = res[31]; // see RQ6
					nxt_core.cc[CC_IZ] = (res[31:0] == 32'h0000_0000);
					nxt_core.cc[CC_IV] = div_ovf; // see RQ7
					nxt_core.cc[CC_IC] = 1'b0;
					nxt_core.cc[CC_XN] = res[63];
					nxt_core.cc[CC_XZ] = (res == 64'h0);
					nxt_core.cc[CC_XV] = 1'b0;
					nxt_core.cc[CC_XC] = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cur_ff <= '0;
			cur_ff.wait_req <= 1'b1;
		end else begin
			cur_ff <= nxt_core;
		end
	end

	assign readdata = cur_ff.rdata;
	assign waitrequest = cur_ff.wait_req;
	assign wb_valid = cur_ff.wb_valid;
	assign wb_dest = cur_ff.instr[RD_LSB +: RD_W];
	assign wb_data = cur_ff.result;
	assign cond_codes = cur_ff.cc;
	assign illegal_op = cur_ff.illegal_pulse;

	// =====================================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	logic cmd_go;
	assign cmd_go = write && !cur_ff.wait_req && address == OFS_CMD && cur_ff.st == ST_IDLE
		&& byteenable[0];

	hi_imm_layout_a: assert property (cmd_go && writedata[2:0] == OP_HI_IMM |=>
		nxt_core.st == ST_IDLE && (cur_ff.nop || (cur_ff.result[63:32] == 32'h0
		&& cur_ff.result[9:0] == 10'h0 && cur_ff.wb_valid))) // see RQ9
		else $error("high immediate result badly formed");
	hi_imm_cc_a: assert property (cmd_go && writedata[2:0] == OP_HI_IMM |=> $stable(cur_ff.cc)) // see RQ10
		else $error("high immediate changed flags");
	hi_imm_nop_a: assert property (cmd_go && writedata[2:0] == OP_HI_IMM && cur_ff.instr == 32'h0
		|=> cur_ff.nop && !cur_ff.wb_valid) // see RQ11
		else $error("nop form wrote a result");
	shift_cc_a: assert property (cmd_go && writedata[2:0] >= OP_SLL |=> $stable(cur_ff.cc)) // see RQ19
		else $error("shift changed flags");
	srl_upper_a: assert property (cur_ff.wb_valid && cur_ff.op == OP_SRL
		&& !cur_ff.instr[BIT_WIDE_SEL] |-> cur_ff.result[63:32] == 32'h0) // see RQ14
		else $error("word logical shift left upper bits");
	sra_upper_a: assert property (cur_ff.wb_valid && cur_ff.op == OP_SRA
		&& !cur_ff.instr[BIT_WIDE_SEL] |-> cur_ff.result[63:32] == {32{cur_ff.result[31]}}) // see RQ16
		else $error("word arithmetic shift upper fill wrong");
	div_sat_a: assert property (cur_ff.st == ST_DIV && div_done && div_ovf && !div_dz
		|=> cur_ff.result == (u_div.cur_ff.neg ? SAT_NEG : SAT_POS)) // see RQ4
		else $error("overflow not saturated");
	div_extend_a: assert property (cur_ff.wb_valid && cur_ff.op <= OP_DIVCC && !cur_ff.ovf
		|-> cur_ff.result[63:32] == {32{cur_ff.result[31]}}) // see RQ5
		else $error("quotient not sign extended");
	div_cc_keep_a: assert property (cur_ff.st == ST_DIV && cur_ff.op == OP_DIV
		|=> $stable(cur_ff.cc)) // see RQ6
		else $error("plain divide changed flags");
	div_cc_set_a: assert property (cur_ff.wb_valid && cur_ff.op == OP_DIVCC |->
		cur_ff.cc[CC_IN] == cur_ff.result[31] && cur_ff.cc[CC_IV] == cur_ff.ovf
		&& !cur_ff.cc[CC_IC] && !cur_ff.cc[CC_XC]) // see RQ7
		else $error("divide flags wrong");
	div_illegal_a: assert property (cmd_go && writedata[2:0] <= OP_DIVCC
		&& !cur_ff.instr[BIT_IMM_SEL] && cur_ff.instr[12:5] != 8'h00
		|=> illegal_op && cur_ff.st == ST_IDLE) // see RQ8
		else $error("reserved divide bits not trapped");
	shift_illegal_a: assert property (cmd_go && writedata[2:0] >= OP_SLL && writedata[2:0] <= OP_SRA
		&& !cur_ff.instr[BIT_WIDE_SEL] && cur_ff.instr[11:5] != 7'h00
		|=> illegal_op && !wb_valid) // see RQ20
		else $error("reserved shift bits not trapped");
	bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus answer late");

	ovf_c: cover property (cur_ff.wb_valid && cur_ff.ovf);
	nop_c: cover property (cur_ff.done && cur_ff.nop);
	wide_sra_c: cover property (cur_ff.wb_valid && cur_ff.op == OP_SRA && cur_ff.instr[BIT_WIDE_SEL]);
	illegal_c: cover property (illegal_op);
endmodule

// >>> tb/int_div_shift_tb.sv
`timescale 1ns/1ps
module int_div_shift_tb;
	import alu_pkg::*;
	// ==========================================================
	// signals
	localparam logic [63:0] SA = 64'h8000_0001_8000_00F0;
	logic clk;
	logic reset_n;
	logic [ADDR_W-1:0] address;
	logic read;
	logic write;
	logic [31:0] writedata;
	logic [3:0] byteenable;
	logic [31:0] readdata;
	logic waitrequest;
	logic wb_valid;
	logic [RD_W-1:0] wb_dest;
	logic [63:0] wb_data;
	logic [CC_W-1:0] cond_codes;
	logic illegal_op;
	int fails;
	int tests_run;
	logic wb_seen;
	logic ill_seen;
	logic [63:0] wb_got;
	logic [31:0] rdata;
	logic [31:0] st;

	int_div_shift dut (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .wb_valid(wb_valid),
		.wb_dest(wb_dest), .wb_data(wb_data), .cond_codes(cond_codes),
		.illegal_op(illegal_op));

	// ==========================================================
	// clock and pulse capture; pulses last one cycle, so latch them
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (wb_valid === 1'b1) begin
			wb_seen = 1'b1;
			wb_got = wb_data;
		end
		if (illegal_op === 1'b1) begin
			ill_seen = 1'b1;
		end
	end

	// ==========================================================
	// tasks
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one avalon access; request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		n = 0;
		address <= a;
		writedata <= d;
		read <= ~wr;
		write <= wr;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		rdata = readdata;
		read <= 1'b0;
		write <= 1'b0;
		// an idle edge between accesses keeps each strobe to one change per step
		@(posedge clk);
		if (n >= 50) begin
			fails++;
			$display("CHECK FAILED waitrequest expected 0 seen 1");
			end_sim();
		end
	endtask

	// load operands, issue a command, poll until idle, then compare
	task automatic run(input logic [2:0] op, input logic [31:0] ins, input logic [63:0] a,
		input logic [31:0] b, input logic [31:0] hw, input logic e_wb, input logic e_ill,
		input logic [63:0] e_res);
		int n;
		bus(1'b1, OFS_INSTR, ins);
		bus(1'b1, OFS_SRC_A_LO, a[31:0]);
		bus(1'b1, OFS_SRC_A_HI, a[63:32]);
		bus(1'b1, OFS_SRC_B_LO, b);
		bus(1'b1, OFS_SRC_B_HI, 32'hFFFF_FFFF);
		bus(1'b1, OFS_HIGH_WORD, hw);
		wb_seen = 1'b0;
		ill_seen = 1'b0;
		bus(1'b1, OFS_CMD, {29'h0, op});
		n = 0;
		do begin
			bus(1'b0, OFS_STATUS, 32'h0);
			n++;
		end while ((rdata[ST_BUSY] !== 1'b0 || rdata[ST_DONE] !== 1'b1) && n < 100);
		st = rdata;
		if (n >= 100) begin
			fails++;
			$display("CHECK FAILED status done expected 1 seen 0");
			end_sim();
		end
		chk("illegal", {63'h0, e_ill}, {63'h0, ill_seen});
		if (e_wb !== 1'bx) begin
			chk("wb_valid", {63'h0, e_wb}, {63'h0, wb_seen});
		end
		if (e_wb === 1'b1) begin
			chk("wb_data", e_res, wb_got);
			bus(1'b0, OFS_RESULT_LO, 32'h0);
			chk("result_lo", {32'h0, e_res[31:0]}, {32'h0, rdata});
			bus(1'b0, OFS_RESULT_HI, 32'h0);
			chk("result_hi", {32'h0, e_res[63:32]}, {32'h0, rdata});
		end
	endtask

	// ==========================================================
	// main sequence
	initial begin
		reset_n = 1'b0;
		address = '0;
		read = 1'b0;
		write = 1'b0;
		writedata = '0;
		byteenable = 4'hF;
		fails = 0;
		tests_run = 0;
		wb_seen = 1'b0;
		ill_seen = 1'b0;
		wb_got = '0;
		rdata = '0;
		st = '0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		chk("cc_reset", 64'h0, {56'h0, cond_codes});
		bus(1'b0, 6'h3C, 32'h0);
		chk("unmapped", 64'h0, {32'h0, rdata});
		bus(1'b1, OFS_CC, 32'h0000_00A5);
		$display("test registers done");

		run(OP_DIV, 32'h0200_0000, 64'hFFFF_FFF9, 32'h4, 32'hFFFF_FFFF, 1'b1, 1'b0,
			64'hFFFF_FFFF_FFFF_FFFF);
		chk("wb_dest", 64'h1, {59'h0, wb_dest});
		chk("cc_div", 64'hA5, {56'h0, cond_codes});
		run(OP_DIV, 32'h0200_3FFD, 64'h64, 32'h0, 32'h0, 1'b1, 1'b0,
			64'hFFFF_FFFF_FFFF_FFDF);
		run(OP_DIVCC, 32'h0200_0000, 64'h0, 32'h1, 32'h1, 1'b1, 1'b0, SAT_POS);
		chk("cc_sat_pos", 64'h02, {56'h0, cond_codes});
		chk("ovf", 64'h1, {63'h0, st[ST_OVF]});
		run(OP_DIVCC, 32'h0200_0000, 64'h0, 32'h1, 32'hFFFF_FFFF, 1'b1, 1'b0,
			SAT_NEG);
		chk("cc_sat_neg", 64'h8A, {56'h0, cond_codes});
		run(OP_DIVCC, 32'h0200_0000, 64'h0, 32'h5, 32'h0, 1'b1, 1'b0, 64'h0);
		chk("cc_zero", 64'h44, {56'h0, cond_codes});
		run(OP_DIV, 32'h0200_0020, 64'h8, 32'h2, 32'h0, 1'b0, 1'b1, 64'h0);
		run(OP_DIV, 32'h0200_0000, 64'h8, 32'h0, 32'h0, 1'b0, 1'b0, 64'h0);
		chk("div_zero", 64'h1, {63'h0, st[ST_DIVZERO]});
		$display("test divide done");

		run(OP_HI_IMM, 32'h063F_FFFF, SA, 32'h0, 32'h0, 1'b1, 1'b0,
			64'h0000_0000_FFFF_FC00);
		chk("wb_dest", 64'h3, {59'h0, wb_dest});
		chk("cc_hi_imm", 64'h44, {56'h0, cond_codes});
		run(OP_HI_IMM, 32'h0000_0000, SA, 32'h0, 32'h0, 1'b0, 1'b0, 64'h0);
		chk("nop", 64'h1, {63'h0, st[ST_NOP]});
		$display("test high immediate done");

		run(OP_SLL, 32'h0200_2004, SA, 32'h0, 32'h0, 1'b1, 1'b0,
			64'h0000_0018_0000_0F00);
		run(OP_SLL, 32'h0200_1000, SA, 32'h41, 32'h0, 1'b1, 1'b0,
			64'h0000_0003_0000_01E0);
		run(OP_SRL, 32'h0200_0000, SA, 32'h25, 32'h0, 1'b1, 1'b0,
			64'h0000_0000_0400_0007);
		run(OP_SRL, 32'h0200_2000, SA, 32'h0, 32'h0, 1'b1, 1'b0,
			64'h0000_0000_8000_00F0);
		run(OP_SRL, 32'h0200_3024, SA, 32'h0, 32'h0, 1'b1, 1'b0,
			64'h0000_0000_0800_0000);
		run(OP_SRL, 32'h0200_303F, SA, 32'h0, 32'h0, 1'b1, 1'b0, 64'h1);
		run(OP_SRA, 32'h0200_2000, SA, 32'h0, 32'h0, 1'b1, 1'b0,
			64'hFFFF_FFFF_8000_00F0);
		run(OP_SRA, 32'h0200_2008, SA, 32'h0, 32'h0, 1'b1, 1'b0,
			64'hFFFF_FFFF_FF80_0000);
		run(OP_SRA, 32'h0200_1000, SA, 32'h3F, 32'h0, 1'b1, 1'b0,
			64'hFFFF_FFFF_FFFF_FFFF);
		chk("cc_shift", 64'h44, {56'h0, cond_codes});
		run(OP_SLL, 32'h0200_2020, SA, 32'h0, 32'h0, 1'b0, 1'b1, 64'h0);
		run(OP_SRL, 32'h0200_3040, SA, 32'h0, 32'h0, 1'b0, 1'b1, 64'h0);
		run(OP_SRA, 32'h0200_1020, SA, 32'h1, 32'h0, 1'b0, 1'b1, 64'h0);
		$display("test shifts done");
		end_sim();
	end
endmodule
